// ==== hdl/sccl_pkg.sv ====
// Package for the smart card character link: register map, fields, timing.
// Assumes a single 40 MHz system clock and an APB register bus.
package sccl_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] SCCL_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] SCCL_ADDR_STATUS = 8'h04;
  localparam logic [7:0] SCCL_ADDR_TXDATA = 8'h08;
  localparam logic [7:0] SCCL_ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] SCCL_ADDR_MASK   = 8'h10;
  localparam logic [7:0] SCCL_ADDR_DIV    = 8'h14;

  // ==========================================================================
  // Control fields
  localparam int SCCL_CTRL_TX_EN  = 0;
  localparam int SCCL_CTRL_RX_EN  = 1;
  localparam int SCCL_CTRL_ODD    = 2;
  localparam int SCCL_CTRL_TIE    = 3;
  localparam int SCCL_CTRL_RIE    = 4;
  localparam int SCCL_CTRL_W      = 5;

  // Status fields
  localparam int SCCL_ST_PARITY   = 0;
  localparam int SCCL_ST_RXFULL   = 1;
  localparam int SCCL_ST_ERRSIG   = 2;
  localparam int SCCL_ST_TXEND    = 3;
  localparam int SCCL_ST_W        = 4;

  localparam logic [SCCL_ST_W-1:0] SCCL_ST_RESET = 4'h8;
  localparam logic [SCCL_ST_W-1:0] SCCL_MASK_RESET = 4'h0;

  // ==========================================================================
  // Timing
  localparam int SCCL_ETU_CYCLES  = 372;
  localparam int SCCL_SAMPLE_CYC  = 186;
  localparam int SCCL_FRAME_BITS  = 10;
  localparam int SCCL_DATA_BITS   = 8;
  localparam int SCCL_GUARD_BITS  = 2;
  localparam int SCCL_ERR_FIRST   = 11;
  localparam int SCCL_ERR_LAST    = 12;
  localparam int SCCL_CLK_MHZ     = 40;
  localparam int SCCL_DIV_W       = 16;
  localparam logic [SCCL_DIV_W-1:0] SCCL_DIV_RESET = 16'h0000;

  typedef enum logic [1:0] {
    SCCL_IDLE,
    SCCL_RX,
    SCCL_TX
  } sccl_mode_e;

endpackage : sccl_pkg

// ==== hdl/sccl_link.sv ====
// Smart card character link: half-duplex 10-bit frames with error signal.
// Assumes APB master on i_sys_clk; card line is open drain, pulled up outside.
//
// Operation
// - Bit period is 372 base clock ticks
// - Start falling edge resyncs receive timing
// - Sample each bit at tick 186
// - Frame is start, eight data, parity
// - Parity failure sets flag, error interrupt
// - Failed parity never sets receive full
// - Good parity sets receive full, interrupt
// - Good frame leaves line released in guard
// - Card error signal sets error flag
// - Errored transmission never sets transmit end
// - No error signal leaves flag clear
// - Clean finish sets transmit end, interrupt
// - Error signal triggers automatic retransmission
// - Transmit done interrupt never raised
// - Received byte stored despite parity error
module sccl_link
  import sccl_pkg::*;
#(
  parameter int ETU     = SCCL_ETU_CYCLES,
  parameter int SAMPLE  = SCCL_SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // Card data line
  input  wire logic        i_io,
  output logic             o_io,
  output logic             o_io_oe,
  // Interrupts
  output logic             o_irq,
  output logic             o_comm_error_irq,
  output logic             o_receive_full_irq,
  output logic             o_transmit_empty_irq,
  output logic             o_transmit_done_irq
);

  // ==========================================================================
  // Registers and state
  logic [SCCL_CTRL_W-1:0] ctrl_reg;
  logic [SCCL_ST_W-1:0]   status_reg;
  logic [SCCL_ST_W-1:0]   mask_reg;
  logic [SCCL_DIV_W-1:0]  div_reg;
  logic [SCCL_DIV_W-1:0]  div_cnt_reg;
  logic [7:0]             transmit_data_reg;
  logic [7:0]             receive_data_reg;
  logic [8:0]             shift_reg;
  logic [8:0]             tick_reg;
  logic [3:0]             bit_reg;
  logic                   io_m_reg;
  logic                   io_s_reg;
  logic                   io_d_reg;
  logic                   tx_pend_reg;
  logic                   err_seen_reg;
  logic                   drive_reg;
  logic                   drive_val_reg;
  sccl_mode_e             mode_reg;

  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction : par_of

  // ==========================================================================
  // Decode
  wire        wr_en     = i_psel & i_penable & i_pwrite;
  wire        rd_en     = i_psel & i_penable & ~i_pwrite;
  wire        hit_ctrl  = (i_paddr == SCCL_ADDR_CTRL);
  wire        hit_stat  = (i_paddr == SCCL_ADDR_STATUS);
  wire        hit_tx    = (i_paddr == SCCL_ADDR_TXDATA);
  wire        hit_rx    = (i_paddr == SCCL_ADDR_RXDATA);
  wire        hit_mask  = (i_paddr == SCCL_ADDR_MASK);
  wire        hit_div   = (i_paddr == SCCL_ADDR_DIV);
  wire        hit_any   = hit_ctrl | hit_stat | hit_tx | hit_rx | hit_mask | hit_div;
  wire        stat_rd   = rd_en & hit_stat;
  wire        tx_wr     = wr_en & hit_tx;
  wire        receive_irq_enable       = ctrl_reg[SCCL_CTRL_RIE];
  wire        transmit_irq_enable       = ctrl_reg[SCCL_CTRL_TIE];
  wire        odd       = ctrl_reg[SCCL_CTRL_ODD];

  // Base clock enable from divider
  wire        base_en   = (div_cnt_reg == div_reg);

  // Bit timing
  wire        etu_last  = base_en && (tick_reg == 9'(ETU - 1));
  wire        mid_pt    = base_en && (tick_reg == 9'(SAMPLE - 1));
  wire        start_fall = io_d_reg & ~io_s_reg;
  wire        rx_start  = (mode_reg == SCCL_IDLE) & ctrl_reg[SCCL_CTRL_RX_EN]
                          & ~tx_pend_reg & start_fall;
  wire        tx_start  = (mode_reg == SCCL_IDLE) & tx_pend_reg
                          & ctrl_reg[SCCL_CTRL_TX_EN] & io_s_reg;
  // Data already shifted in; parity bit is on the line at this sample
  wire        rx_par_ok = (par_of(shift_reg[8:1], odd) == io_s_reg);
  wire        par_bit   = mid_pt && (bit_reg == 4'(SCCL_FRAME_BITS - 1));
  wire        err_samp  = mid_pt && (bit_reg == 4'(SCCL_ERR_FIRST));
  wire        frame_end = etu_last && (bit_reg == 4'(SCCL_ERR_LAST));

  // Flag events
  wire        ev_par    = (mode_reg == SCCL_RX) & par_bit & ~rx_par_ok;
  wire        ev_rxfull = (mode_reg == SCCL_RX) & par_bit & rx_par_ok;
  wire        ev_errsig = (mode_reg == SCCL_TX) & err_samp & ~io_s_reg;
  wire        ev_txend  = (mode_reg == SCCL_TX) & frame_end & ~err_seen_reg;
  wire [SCCL_ST_W-1:0] ev_vec = {ev_txend, ev_errsig, ev_rxfull, ev_par};
  wire [SCCL_ST_W-1:0] st_hit = status_reg & mask_reg;

  // ==========================================================================
  // APB registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_reg          <= '0;
      mask_reg          <= SCCL_MASK_RESET;
      div_reg           <= SCCL_DIV_RESET;
      transmit_data_reg <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_reg <= i_pwdata[SCCL_CTRL_W-1:0];
      if (hit_mask) mask_reg <= i_pwdata[SCCL_ST_W-1:0];
      if (hit_div) div_reg <= i_pwdata[SCCL_DIV_W-1:0];
      if (hit_tx) transmit_data_reg <= i_pwdata[7:0];
    end
  end

  // Sticky status, set wins over read-clear
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) status_reg <= SCCL_ST_RESET;
    else if (stat_rd) status_reg <= (status_reg & ~o_prdata[SCCL_ST_W-1:0]) | ev_vec;
    else status_reg <= status_reg | ev_vec;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~hit_any;
      o_prdata  <= '0;
      if (i_psel & ~i_penable & ~i_pwrite) begin
        if (hit_ctrl) o_prdata <= 32'(ctrl_reg);
        if (hit_stat) o_prdata <= 32'(status_reg);
        if (hit_tx)   o_prdata <= 32'(transmit_data_reg);
        if (hit_rx)   o_prdata <= 32'(receive_data_reg);
        if (hit_mask) o_prdata <= 32'(mask_reg);
        if (hit_div)  o_prdata <= 32'(div_reg);
      end
    end
  end

  // ==========================================================================
  // Line synchroniser and base clock divider
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      io_m_reg    <= 1'b1;
      io_s_reg    <= 1'b1;
      io_d_reg    <= 1'b1;
      div_cnt_reg <= '0;
    end else begin
      io_m_reg    <= i_io;
      io_s_reg    <= io_m_reg;
      io_d_reg    <= io_s_reg;
      div_cnt_reg <= base_en ? '0 : div_cnt_reg + 1'b1;
    end
  end

  // ==========================================================================
  // Frame engine
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode_reg         <= SCCL_IDLE;
      tick_reg         <= '0;
      bit_reg          <= '0;
      shift_reg        <= '0;
      tx_pend_reg      <= 1'b0;
      err_seen_reg     <= 1'b0;
      drive_reg        <= 1'b0;
      drive_val_reg    <= 1'b1;
      receive_data_reg <= '0;
    end else begin
      if (tx_wr) tx_pend_reg <= 1'b1;
      if (base_en) tick_reg <= etu_last ? '0 : tick_reg + 1'b1;
      if (etu_last) bit_reg <= bit_reg + 1'b1;
      unique case (mode_reg)
        SCCL_IDLE: begin
          drive_reg <= 1'b0;
          if (tx_start) begin
            mode_reg      <= SCCL_TX;
            tick_reg      <= '0;
            bit_reg       <= '0;
            err_seen_reg  <= 1'b0;
            shift_reg     <= {par_of(transmit_data_reg, odd), transmit_data_reg};
            drive_reg     <= 1'b1;
            drive_val_reg <= 1'b0;
          end else if (rx_start) begin
            mode_reg <= SCCL_RX;
            tick_reg <= '0;
            bit_reg  <= '0;
          end
        end
        SCCL_RX: begin
          if (mid_pt && bit_reg != '0 && bit_reg < 4'(SCCL_FRAME_BITS))
            shift_reg <= {io_s_reg, shift_reg[8:1]};
          if (par_bit) begin
            receive_data_reg <= shift_reg[8:1];
            err_seen_reg     <= (par_of(shift_reg[8:1], odd) != io_s_reg);
          end
          if (etu_last && bit_reg == 4'(SCCL_FRAME_BITS - 1) + 4'(1))
            drive_reg <= err_seen_reg;
          if (etu_last && bit_reg == 4'(SCCL_ERR_FIRST))
            drive_reg <= 1'b0;
          drive_val_reg <= 1'b0;
          if (frame_end) mode_reg <= SCCL_IDLE;
        end
        SCCL_TX: begin
          if (etu_last && bit_reg < 4'(SCCL_FRAME_BITS - 1)) begin
            drive_val_reg <= shift_reg[0];
            shift_reg     <= {1'b1, shift_reg[8:1]};
          end
          if (etu_last && bit_reg == 4'(SCCL_FRAME_BITS - 1))
            drive_reg <= 1'b0;
          if (ev_errsig) err_seen_reg <= 1'b1;
          if (frame_end) begin
            mode_reg <= SCCL_IDLE;
            if (!err_seen_reg) tx_pend_reg <= tx_wr;
          end
        end
        default: mode_reg <= SCCL_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_io                 <= 1'b1;
      o_io_oe              <= 1'b0;
      o_irq                <= 1'b0;
      o_comm_error_irq     <= 1'b0;
      o_receive_full_irq   <= 1'b0;
      o_transmit_empty_irq <= 1'b0;
      o_transmit_done_irq  <= 1'b0;
    end else begin
      o_io                 <= drive_val_reg;
      o_io_oe              <= drive_reg & ~drive_val_reg;
      o_irq                <= |st_hit;
      o_comm_error_irq     <= receive_irq_enable & (status_reg[SCCL_ST_PARITY] | status_reg[SCCL_ST_ERRSIG]);
      o_receive_full_irq   <= receive_irq_enable & status_reg[SCCL_ST_RXFULL];
      o_transmit_empty_irq <= transmit_irq_enable & status_reg[SCCL_ST_TXEND];
      o_transmit_done_irq  <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  AST_RXFULL_NOT_ON_ERR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ev_par |-> ##1 !($rose(status_reg[SCCL_ST_RXFULL]) && !ev_rxfull))
    else $error("receive full set on parity error");
  AST_PAR_SETS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ev_par |=> status_reg[SCCL_ST_PARITY])
    else $error("parity flag not set");
  AST_ERRSIG_SETS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ev_errsig |=> status_reg[SCCL_ST_ERRSIG])
    else $error("error signal flag not set");
  AST_TXEND_CLEAN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (frame_end && mode_reg == SCCL_TX && err_seen_reg) |=> !$rose(status_reg[SCCL_ST_TXEND]))
    else $error("transmit end after error signal");
  AST_NO_DONE_IRQ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_transmit_done_irq)
    else $error("transmit done interrupt raised");
  AST_RXFULL_IRQ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (receive_irq_enable && status_reg[SCCL_ST_RXFULL]) |=> o_receive_full_irq)
    else $error("receive full interrupt missing");
  AST_TXE_IRQ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (transmit_irq_enable && status_reg[SCCL_ST_TXEND]) |=> o_transmit_empty_irq)
    else $error("transmit empty interrupt missing");
  AST_RETX: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (frame_end && mode_reg == SCCL_TX && err_seen_reg) |=> tx_pend_reg)
    else $error("no retransmission after error");

endmodule : sccl_link

// ==== testbench/sccl_card_model.sv ====
// Behavioural smart card on the shared open-drain data line.
// Assumes the line is pulled up outside and that each side only pulls it low.
module sccl_card_model #(
  parameter int ETU    = 20,
  parameter int SAMPLE = 10
) (
  // Clock and line
  input  wire logic       i_sys_clk,
  input  wire logic       i_line,
  // Card transmit control
  input  wire logic       i_send,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_bad_par,
  input  wire logic [1:0] i_nacks,
  // Observations
  output logic            o_low,
  output logic [7:0]      o_rx_byte,
  output logic [7:0]      o_frames,
  output logic            o_err_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [9:0] bits;
  logic [1:0] nacked = 2'd0;
  logic       line_q = 1'b1;

  initial begin
    o_low = 1'b0;
    o_rx_byte = 8'h00;
    o_frames = 8'h00;
    o_err_seen = 1'b0;
  end

  // ==========================================================================
  // Card sends one frame, then watches both error window bit times
  task automatic send_frame();
    bits = {^i_byte ^ i_bad_par, i_byte, 1'b0};
    for (int k = 0; k < 10; k++) begin
      o_low <= ~bits[k];
      repeat (ETU) @(posedge i_sys_clk);
    end
    o_low <= 1'b0;
    repeat (SAMPLE) @(posedge i_sys_clk);
    o_err_seen <= ~i_line;
    repeat (ETU) @(posedge i_sys_clk);
    o_err_seen <= o_err_seen | ~i_line;
    repeat (ETU - SAMPLE) @(posedge i_sys_clk);
  endtask : send_frame

  // ==========================================================================
  // Card receives one frame, answering with an error signal on request
  task automatic recv_frame();
    repeat (SAMPLE) @(posedge i_sys_clk);
    for (int k = 1; k < 10; k++) begin
      repeat (ETU) @(posedge i_sys_clk);
      bits[k] = i_line;
    end
    repeat (ETU - SAMPLE) @(posedge i_sys_clk);
    if (nacked < i_nacks) begin
      nacked = nacked + 2'd1;
      o_low <= 1'b1;
    end
    repeat (ETU + SAMPLE + ETU / 4) @(posedge i_sys_clk);
    o_low <= 1'b0;
    // Return early so a prompt retransmission start is not missed
    repeat (ETU - SAMPLE - ETU / 4 - 3) @(posedge i_sys_clk);
    o_rx_byte <= bits[8:1];
    o_frames <= o_frames + 8'd1;
  endtask : recv_frame

  always begin
    @(posedge i_sys_clk);
    if (i_send) begin
      send_frame();
    end else if (line_q && !i_line) begin
      recv_frame();
    end
    line_q = i_line;
  end
endmodule : sccl_card_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the smart card character link.
// Assumes a 40 MHz clock, a shortened bit period and the card model on the line.
module testbench;
  import sccl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int ETU    = 20;
  localparam int SAMPLE = 10;

  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic o_pready, o_pslverr, o_io, o_io_oe, o_irq;
  logic o_comm_error_irq, o_receive_full_irq, o_transmit_empty_irq, o_transmit_done_irq;
  logic [31:0] o_prdata, rdata;
  logic rerr, card_low, card_err, card_send_r = 1'b0, card_bad = 1'b0;
  logic [7:0] card_byte = 8'h00, card_rx, card_frames, f0;
  logic [1:0] card_nacks = 2'd0;
  int mismatches = 0;
  int checks = 0;
  wire line = !((o_io_oe && !o_io) || card_low);
  wire [2:0] irqs = {o_comm_error_irq, o_receive_full_irq, o_transmit_empty_irq};

  always #12.5 i_sys_clk = ~i_sys_clk;

  sccl_link #(.ETU(ETU), .SAMPLE(SAMPLE)) sccl_link_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_io(line), .o_io(o_io),
    .o_io_oe(o_io_oe), .o_irq(o_irq), .o_comm_error_irq(o_comm_error_irq),
    .o_receive_full_irq(o_receive_full_irq), .o_transmit_empty_irq(o_transmit_empty_irq),
    .o_transmit_done_irq(o_transmit_done_irq));

  sccl_card_model #(.ETU(ETU), .SAMPLE(SAMPLE)) sccl_card_model_i (
    .i_sys_clk(i_sys_clk), .i_line(line), .i_send(card_send_r), .i_byte(card_byte),
    .i_bad_par(card_bad), .i_nacks(card_nacks), .o_low(card_low), .o_rx_byte(card_rx),
    .o_frames(card_frames), .o_err_seen(card_err));

  // ==========================================================================
  // Shared helpers
  task automatic test_done();
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_paddr <= a;
    i_pwrite <= w;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rdata = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk(rdata, exp);
  endtask : rd_chk

  task automatic wait_irq(input int k);
    for (int n = 0; n < 1000 && irqs[k] !== 1'b1; n++) @(posedge i_sys_clk);
    chk(irqs[k], 1'b1);
  endtask : wait_irq

  task automatic card_send(input logic [7:0] b, input logic bad);
    @(posedge i_sys_clk);
    card_send_r <= 1'b1;
    card_byte <= b;
    card_bad <= bad;
    @(posedge i_sys_clk);
    card_send_r <= 1'b0;
  endtask : card_send

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(SCCL_ADDR_STATUS, 32'h0000_0008);
    rd_chk(SCCL_ADDR_MASK, 32'h0000_0000);
    rd_chk(8'h18, 32'h0000_0000);
    chk(rerr, 1'b1);
    chk(o_transmit_done_irq, 1'b0);
  endtask : t_reset

  task automatic t_rx_good();
    apb(SCCL_ADDR_CTRL, 1'b1, 32'h0000_0012);
    apb(SCCL_ADDR_MASK, 1'b1, 32'h0000_0002);
    card_send(8'hA5, 1'b0);
    wait_irq(1);
    repeat (3 * ETU) @(posedge i_sys_clk);
    chk(card_err, 1'b0);
    chk(o_irq, 1'b1);
    chk(o_comm_error_irq, 1'b0);
    rd_chk(SCCL_ADDR_RXDATA, 32'h0000_00A5);
    rd_chk(SCCL_ADDR_STATUS, 32'h0000_0002);
    repeat (3) @(posedge i_sys_clk);
    chk(o_irq, 1'b0);
  endtask : t_rx_good

  task automatic t_rx_bad();
    card_send(8'h5A, 1'b1);
    wait_irq(2);
    repeat (3 * ETU) @(posedge i_sys_clk);
    chk(card_err, 1'b1);
    chk(o_receive_full_irq, 1'b0);
    chk(o_irq, 1'b0);
    rd_chk(SCCL_ADDR_RXDATA, 32'h0000_005A);
    rd_chk(SCCL_ADDR_STATUS, 32'h0000_0001);
  endtask : t_rx_bad

  task automatic t_tx_clean();
    apb(SCCL_ADDR_CTRL, 1'b1, 32'h0000_0019);
    f0 = card_frames;
    apb(SCCL_ADDR_TXDATA, 1'b1, 32'h0000_003C);
    wait_irq(0);
    repeat (ETU) @(posedge i_sys_clk);
    chk(o_comm_error_irq, 1'b0);
    chk(card_frames, f0 + 8'd1);
    chk(card_rx, 8'h3C);
    chk(o_transmit_done_irq, 1'b0);
    rd_chk(SCCL_ADDR_STATUS, 32'h0000_0008);
  endtask : t_tx_clean

  task automatic t_tx_nack();
    @(posedge i_sys_clk);
    card_nacks <= 2'd1;
    f0 = card_frames;
    apb(SCCL_ADDR_TXDATA, 1'b1, 32'h0000_00C3);
    wait_irq(2);
    chk(o_transmit_empty_irq, 1'b0);
    rd_chk(SCCL_ADDR_STATUS, 32'h0000_0004);
    wait_irq(0);
    repeat (ETU) @(posedge i_sys_clk);
    chk(card_frames, f0 + 8'd2);
    chk(card_rx, 8'hC3);
    rd_chk(SCCL_ADDR_STATUS, 32'h0000_0008);
  endtask : t_tx_nack

  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset();
    t_rx_good();
    t_rx_bad();
    t_tx_clean();
    t_tx_nack();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    mismatches++;
    test_done();
  end
endmodule : testbench
